//--- shared/power_seq_pkg.sv
package power_seq_pkg;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   // One flag per supply, in the order of the enable field
   typedef struct packed {
      logic io;
      logic pll;
      logic analog;
      logic core;
   } supply_t;

   // Sequencer states; declaration order gives the status encoding 0..7
   typedef enum logic [2:0] {
      ST_RESET,
      ST_ASLEEP,
      ST_WAKING_PHASE_ONE,
      ST_WAKING_PHASE_TWO,
      ST_AWAKE_WAIT,
      ST_AWAKE,
      ST_SLEEP_PHASE_ONE,
      ST_SLEEP_PHASE_TWO
   } seq_state_t;

   // ------------------------------------------------------------
   // Register numbers on the peripheral access path
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_WAKING_PHASE2 = 8'h14;
   localparam logic [7:0] OFS_AWAKE = 8'h18;
   localparam logic [7:0] OFS_SLEEP_PHASE1 = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_CONVERTER_CTRL = 8'h2c;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_CORE_EN = 0;
   localparam int BIT_ANALOG_EN = 1;
   localparam int BIT_PLL_EN = 4;
   localparam int BIT_IO_EN = 5;
   localparam int BIT_CORE_PFM = 8;
   localparam int BIT_ANALOG_PFM = 9;
   localparam int BIT_TILE_CLK_GATE = 14;
   localparam int DWELL_LSB = 16;
   localparam int DWELL_W = 5;
   localparam int STATE_LSB = 16;
   localparam int PREV_CORE_EN = 24;
   localparam int PREV_ANALOG_EN = 25;
   localparam int PREV_PLL_EN = 28;
   localparam int PREV_IO_EN = 29;
   localparam int BIT_CORE_MASTER = 0;
   localparam int BIT_ANALOG_MASTER = 1;

   // ------------------------------------------------------------
   // Writable masks (reserved and read-only bits excluded) and the applied-settings mask
   // ------------------------------------------------------------
   localparam logic [31:0] MASK_STATE_DWELL = 32'h001f_4331;
   localparam logic [31:0] MASK_STATE_NODWELL = 32'h0000_4331;
   localparam logic [31:0] MASK_CONVERTER = 32'h0000_0003;
   localparam logic [31:0] MASK_SETTINGS = 32'h0000_4333;

   // ------------------------------------------------------------
   // Values after reset and fixed settings
   // ------------------------------------------------------------
   localparam logic [31:0] RST_WAKING_PHASE2 = 32'h0010_0033;
   localparam logic [31:0] RST_AWAKE = 32'h0000_0033;
   localparam logic [31:0] RST_SLEEP_PHASE1 = 32'h0010_0020;
   localparam logic [31:0] RST_CONVERTER = 32'h0000_0003;
   localparam logic [31:0] CFG_WAKING_PHASE1 = 32'h0010_0020;
   localparam logic [31:0] CFG_POWERED_DOWN = 32'h0000_4300;
   localparam logic [31:0] RST_STATUS_PREV = 32'h0200_0000;
   localparam logic [4:0] DWELL_LOG_WAKING_PHASE1 = 5'h10;
   localparam logic [4:0] DWELL_LOG_SLEEP_PHASE2 = 5'h10;

endpackage

//--- hw/dwell_timer.sv
`timescale 1ns/100ps

module dwell_timer #(
   parameter int CNT_W = 32
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic [4:0] log2_i,
   output logic done_o
);

   // Cycles left in the current state
   logic [CNT_W-1:0] remaining;

   // ------------------------------------------------------------
   // Down counter
   // ------------------------------------------------------------
   // Loaded with 2^n - 1 on entry so that done rises 2^n - 1 cycles later (1 cycle for n = 0);
   // 33 bits keep 2^31 exact before the cut
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         remaining <= '0;
      end else if (start_i) begin
         remaining <= CNT_W'((33'h1_0000_0000 >> (5'h1f - log2_i)) >> 1) - CNT_W'(1);
      end else if (remaining != '0) begin
         remaining <= remaining - CNT_W'(1);
      end
   end

   // Done flag, registered so it comes straight from a flop
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= !start_i && (remaining <= CNT_W'(1));
      end
   end

endmodule

//--- hw/power_sequence_state_control.sv
`timescale 1ns/100ps

module power_sequence_state_control (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic periph_wr_i,
   input wire logic periph_rd_i,
   input wire logic [7:0] periph_addr_i,
   input wire logic [31:0] periph_wdata_i,
   output logic [31:0] periph_rdata_o,
   output logic periph_ack_o,
   input wire logic wake_req_i,
   input wire logic sleep_req_i,
   input wire power_seq_pkg::supply_t power_good_i,
   output power_seq_pkg::supply_t supply_en_o,
   output logic core_pfm_o,
   output logic analog_pfm_o,
   output logic tile_clk_gate_o
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [31:0] waking_phase2_supply_config; // Word for waking phase two
   logic [31:0] awake_supply_config; // Word for awake and awake-wait
   logic [31:0] sleep_phase1_supply_config; // Word for sleep phase one
   logic [31:0] converter_control; // Master enables of both converters
   logic [31:0] active_cfg; // Settings applied at the pins
   power_seq_pkg::supply_t prev_en; // Enables of the previous state
   power_seq_pkg::seq_state_t state; // Current sequencer state
   power_seq_pkg::seq_state_t next_state; // State for the next cycle
   logic [31:0] next_cfg; // Settings of next_state
   logic [4:0] next_dwell_log; // Dwell exponent of next_state
   logic state_change; // High in the cycle before each state change
   logic dwell_done; // Minimum time in state has passed
   logic supplies_good; // Every enabled supply is good

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Merge a write into a register, touching only writable bits
   function automatic logic [31:0] masked_write(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [31:0] mask);
      masked_write = (old_v & ~mask) | (new_v & mask);
   endfunction

   // Pull the four enables out of a settings word
   function automatic power_seq_pkg::supply_t enables_of(input logic [31:0] w);
      enables_of = '{io: w[power_seq_pkg::BIT_IO_EN], pll: w[power_seq_pkg::BIT_PLL_EN],
                     analog: w[power_seq_pkg::BIT_ANALOG_EN],
                     core: w[power_seq_pkg::BIT_CORE_EN]};
   endfunction

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   // Analog enable bit is read-only, so the masks leave it at reset value
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         waking_phase2_supply_config <= power_seq_pkg::RST_WAKING_PHASE2;
         awake_supply_config <= power_seq_pkg::RST_AWAKE;
         sleep_phase1_supply_config <= power_seq_pkg::RST_SLEEP_PHASE1;
         converter_control <= power_seq_pkg::RST_CONVERTER;
      end else if (periph_wr_i) begin
         case (periph_addr_i)
            power_seq_pkg::OFS_WAKING_PHASE2: begin
               waking_phase2_supply_config <= masked_write(waking_phase2_supply_config,
                  periph_wdata_i, power_seq_pkg::MASK_STATE_DWELL);
            end
            power_seq_pkg::OFS_AWAKE: begin
               awake_supply_config <= masked_write(awake_supply_config,
                  periph_wdata_i, power_seq_pkg::MASK_STATE_NODWELL);
            end
            power_seq_pkg::OFS_SLEEP_PHASE1: begin
               sleep_phase1_supply_config <= masked_write(sleep_phase1_supply_config,
                  periph_wdata_i, power_seq_pkg::MASK_STATE_DWELL);
            end
            power_seq_pkg::OFS_CONVERTER_CTRL: begin
               converter_control <= masked_write(converter_control,
                  periph_wdata_i, power_seq_pkg::MASK_CONVERTER);
            end
            // Status and unmapped numbers ignore writes
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Register read path
   // ------------------------------------------------------------
   // Answer one cycle after any access; unmapped numbers read zero
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         periph_rdata_o <= '0;
         periph_ack_o <= 1'b0;
      end else begin
         periph_ack_o <= periph_rd_i || periph_wr_i;
         if (periph_rd_i) begin
            case (periph_addr_i)
               power_seq_pkg::OFS_WAKING_PHASE2: periph_rdata_o <= waking_phase2_supply_config;
               power_seq_pkg::OFS_AWAKE: periph_rdata_o <= awake_supply_config;
               power_seq_pkg::OFS_SLEEP_PHASE1: periph_rdata_o <= sleep_phase1_supply_config;
               power_seq_pkg::OFS_CONVERTER_CTRL: periph_rdata_o <= converter_control;
               power_seq_pkg::OFS_STATUS: begin
                  periph_rdata_o <= (active_cfg & power_seq_pkg::MASK_SETTINGS)
                     | (32'(state) << power_seq_pkg::STATE_LSB)
                     | (32'(prev_en.io) << power_seq_pkg::PREV_IO_EN)
                     | (32'(prev_en.pll) << power_seq_pkg::PREV_PLL_EN)
                     | (32'(prev_en.analog) << power_seq_pkg::PREV_ANALOG_EN)
                     | (32'(prev_en.core) << power_seq_pkg::PREV_CORE_EN);
               end
               default: periph_rdata_o <= '0;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Advance conditions
   // ------------------------------------------------------------
   // Only supplies actually enabled need to report good
   assign supplies_good = ((enables_of(active_cfg) & ~power_good_i) == '0);
   assign state_change = (next_state != state);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // Fixed ring in encoding order; requests only matter in asleep and awake
   always_comb begin
      next_state = state;
      case (state)
         power_seq_pkg::ST_RESET: begin
            next_state = power_seq_pkg::ST_ASLEEP;
         end
         power_seq_pkg::ST_ASLEEP: begin
            if (wake_req_i) begin
               next_state = power_seq_pkg::ST_WAKING_PHASE_ONE;
            end
         end
         power_seq_pkg::ST_WAKING_PHASE_ONE: begin
            if (dwell_done && supplies_good) begin
               next_state = power_seq_pkg::ST_WAKING_PHASE_TWO;
            end
         end
         power_seq_pkg::ST_WAKING_PHASE_TWO: begin
            if (dwell_done && supplies_good) begin
               next_state = power_seq_pkg::ST_AWAKE_WAIT;
            end
         end
         power_seq_pkg::ST_AWAKE_WAIT: begin
            if (supplies_good) begin
               next_state = power_seq_pkg::ST_AWAKE;
            end
         end
         power_seq_pkg::ST_AWAKE: begin
            if (sleep_req_i) begin
               next_state = power_seq_pkg::ST_SLEEP_PHASE_ONE;
            end
         end
         power_seq_pkg::ST_SLEEP_PHASE_ONE: begin
            if (dwell_done) begin
               next_state = power_seq_pkg::ST_SLEEP_PHASE_TWO;
            end
         end
         power_seq_pkg::ST_SLEEP_PHASE_TWO: begin
            if (dwell_done) begin
               next_state = power_seq_pkg::ST_ASLEEP;
            end
         end
         default: next_state = power_seq_pkg::ST_RESET;
      endcase
   end

   // ------------------------------------------------------------
   // Settings and dwell of the next state
   // ------------------------------------------------------------
   // Converter master bits cut the core and analog enables of the per-state word
   always_comb begin
      next_cfg = power_seq_pkg::CFG_POWERED_DOWN;
      next_dwell_log = power_seq_pkg::DWELL_LOG_SLEEP_PHASE2;
      case (next_state)
         power_seq_pkg::ST_WAKING_PHASE_ONE: begin
            next_cfg = power_seq_pkg::CFG_WAKING_PHASE1;
            next_dwell_log = power_seq_pkg::DWELL_LOG_WAKING_PHASE1;
         end
         power_seq_pkg::ST_WAKING_PHASE_TWO: begin
            next_cfg = waking_phase2_supply_config;
            next_dwell_log = waking_phase2_supply_config[power_seq_pkg::DWELL_LSB +:
                                                         power_seq_pkg::DWELL_W];
         end
         power_seq_pkg::ST_AWAKE_WAIT, power_seq_pkg::ST_AWAKE: begin
            next_cfg = awake_supply_config;
         end
         power_seq_pkg::ST_SLEEP_PHASE_ONE: begin
            next_cfg = sleep_phase1_supply_config;
            next_dwell_log = sleep_phase1_supply_config[power_seq_pkg::DWELL_LSB +:
                                                        power_seq_pkg::DWELL_W];
         end
         // Reset, asleep and sleep phase two keep everything down
         default: begin
         end
      endcase
      next_cfg[power_seq_pkg::BIT_CORE_EN] = next_cfg[power_seq_pkg::BIT_CORE_EN]
         & converter_control[power_seq_pkg::BIT_CORE_MASTER];
      next_cfg[power_seq_pkg::BIT_ANALOG_EN] = next_cfg[power_seq_pkg::BIT_ANALOG_EN]
         & converter_control[power_seq_pkg::BIT_ANALOG_MASTER];
   end

   // ------------------------------------------------------------
   // State register and applied settings
   // ------------------------------------------------------------
   // Settings reload every cycle so software edits take effect in place
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         state <= power_seq_pkg::ST_RESET;
         active_cfg <= power_seq_pkg::CFG_POWERED_DOWN;
      end else begin
         state <= next_state;
         active_cfg <= next_cfg & power_seq_pkg::MASK_SETTINGS;
      end
   end

   // Enables of the state being left, caught on each transition;
   // leaving reset keeps the reset value so software sees it while asleep
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         prev_en <= enables_of(power_seq_pkg::RST_STATUS_PREV >> power_seq_pkg::PREV_CORE_EN);
      end else if (state_change && (state != power_seq_pkg::ST_RESET)) begin
         prev_en <= enables_of(active_cfg);
      end
   end

   // ------------------------------------------------------------
   // Outputs straight from the applied settings flop
   // ------------------------------------------------------------
   assign supply_en_o = enables_of(active_cfg);
   assign core_pfm_o = active_cfg[power_seq_pkg::BIT_CORE_PFM];
   assign analog_pfm_o = active_cfg[power_seq_pkg::BIT_ANALOG_PFM];
   assign tile_clk_gate_o = active_cfg[power_seq_pkg::BIT_TILE_CLK_GATE];

   // ------------------------------------------------------------
   // Dwell timer, restarted on every state entry
   // ------------------------------------------------------------
   dwell_timer #(
      .CNT_W(32)
   ) u_dwell_timer (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .start_i(state_change),
      .log2_i(next_dwell_log),
      .done_o(dwell_done)
   );

endmodule

//--- sim/power_seq_props.sv
`timescale 1ns/100ps

// Watches the register path and the applied settings of the sequencer
module power_seq_props (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic periph_wr_i,
   input wire logic periph_rd_i,
   input wire logic [7:0] periph_addr_i,
   input wire logic [31:0] periph_wdata_i,
   input wire logic [31:0] periph_rdata_o,
   input wire logic periph_ack_o,
   input wire power_seq_pkg::supply_t supply_en_o,
   input wire logic core_pfm_o,
   input wire logic analog_pfm_o,
   input wire logic tile_clk_gate_o
);
   // ------------------------------------------------------------
   // Common clock and reset
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);

   // ------------------------------------------------------------
   // Register path
   // ------------------------------------------------------------
   property p_ack_follows;
      (periph_rd_i || periph_wr_i) |=> periph_ack_o;
   endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("ack missing after strobe");

   property p_ack_cause;
      periph_ack_o |-> $past(periph_rd_i || periph_wr_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");

   // Read data must not drift between reads, software may sample late
   property p_rdata_hold;
      !(periph_ack_o && $past(periph_rd_i)) |-> $stable(periph_rdata_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");

   property p_awake_reserved;
      periph_ack_o && $past(periph_rd_i) && $past(periph_addr_i) == 8'h18
         |-> (periph_rdata_o & 32'hffff_bccc) == 32'h0;
   endproperty
   a_awake_reserved: assert property (p_awake_reserved) else $error("awake word reserved bits set");

   property p_status_reserved;
      periph_ack_o && $past(periph_rd_i) && $past(periph_addr_i) == 8'h24
         |-> (periph_rdata_o & 32'hccf8_bccc) == 32'h0;
   endproperty
   a_status_reserved: assert property (p_status_reserved) else $error("status reserved bits set");

   property p_unmapped_zero;
      periph_ack_o && $past(periph_rd_i)
         && !($past(periph_addr_i) inside {8'h14, 8'h18, 8'h1c, 8'h24, 8'h2c})
         |-> periph_rdata_o == 32'h0;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

   property p_ctrl_readback;
      (periph_wr_i && !periph_rd_i && periph_addr_i == 8'h2c)
         ##1 !periph_wr_i
         ##1 (periph_rd_i && !periph_wr_i && periph_addr_i == 8'h2c)
         |=> periph_rdata_o == ($past(periph_wdata_i, 3) & 32'h3);
   endproperty
   a_ctrl_readback: assert property (p_ctrl_readback) else $error("converter control readback");

   // ------------------------------------------------------------
   // Status mirrors what is driven onto the supplies
   // ------------------------------------------------------------
   property p_status_mirror;
      periph_ack_o && $past(periph_rd_i) && $past(periph_addr_i) == 8'h24
         |-> periph_rdata_o[14] == $past(tile_clk_gate_o)
         && periph_rdata_o[9:8] == $past({analog_pfm_o, core_pfm_o})
         && {periph_rdata_o[5:4], periph_rdata_o[1:0]} == $past(supply_en_o);
   endproperty
   a_status_mirror: assert property (p_status_mirror) else $error("status differs from outputs");
endmodule

bind power_sequence_state_control power_seq_props i_power_seq_props (
   .clk_sys_i(clk_sys_i),
   .reset_i(reset_i),
   .periph_wr_i(periph_wr_i),
   .periph_rd_i(periph_rd_i),
   .periph_addr_i(periph_addr_i),
   .periph_wdata_i(periph_wdata_i),
   .periph_rdata_o(periph_rdata_o),
   .periph_ack_o(periph_ack_o),
   .supply_en_o(supply_en_o),
   .core_pfm_o(core_pfm_o),
   .analog_pfm_o(analog_pfm_o),
   .tile_clk_gate_o(tile_clk_gate_o)
);

//--- sim/tb_top.sv
`timescale 1ns/100ps

module tb_top;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wake = 1'b0;
   logic sleep = 1'b0;
   power_seq_pkg::supply_t pg = 4'h0;
   logic [31:0] rdata;
   logic ack;
   power_seq_pkg::supply_t en;
   logic core_pfm;
   logic analog_pfm;
   logic gate;
   logic [31:0] seen; // Outputs packed in configuration word layout
   int miscompares = 0;
   int checked = 0;

   assign seen = {17'h0, gate, 4'h0, analog_pfm, core_pfm, 2'h0, en.io, en.pll, 2'h0,
      en.analog, en.core};

   always #10 clk_sys_i = ~clk_sys_i;

   power_sequence_state_control i_power_sequence_state_control (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .periph_wr_i(wr), .periph_rd_i(rd),
      .periph_addr_i(addr), .periph_wdata_i(wdata), .periph_rdata_o(rdata),
      .periph_ack_o(ack), .wake_req_i(wake), .sleep_req_i(sleep), .power_good_i(pg),
      .supply_en_o(en), .core_pfm_o(core_pfm), .analog_pfm_o(analog_pfm),
      .tile_clk_gate_o(gate));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   // One idle cycle, then one strobe cycle; ack and data are settled one edge later.
   // The idle cycle keeps a release and the next strobe out of one time step.
   task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_sys_i);
      #1;
      wr = w;
      rd = !w;
      addr = a;
      wdata = d;
      @(posedge clk_sys_i);
      #1;
      wr = 1'b0;
      rd = 1'b0;
      check("ack", 32'h1, {31'h0, ack});
      q = rdata;
   endtask

   task automatic read_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      access(1'b0, a, 32'h0, q);
      check($sformatf("reg %h", a), exp, q);
   endtask

   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      access(1'b1, a, d, q);
   endtask

   // Polls the state field every second cycle; n is the number of reads made
   task automatic wait_state(input logic [2:0] s, input int lim, output int n);
      logic [31:0] q;
      n = 0;
      q = 32'h0;
      while (n < lim && q[18:16] !== s) begin
         access(1'b0, 8'h24, 32'h0, q);
         n++;
      end
      check("state", {29'h0, s}, {29'h0, q[18:16]});
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      check("outputs", power_seq_pkg::CFG_POWERED_DOWN, seen);
      read_chk(8'h14, power_seq_pkg::RST_WAKING_PHASE2);
      read_chk(8'h18, 32'h0000_0033);
      read_chk(8'h1c, power_seq_pkg::RST_SLEEP_PHASE1);
      read_chk(8'h2c, power_seq_pkg::RST_CONVERTER);
      read_chk(8'h24, 32'h0201_4300);
      read_chk(8'h20, 32'h0);
   endtask

   // Reserved and read-only bits keep their value under all-ones and zero
   task automatic t_regs;
      write_reg(8'h18, 32'hffff_ffff);
      read_chk(8'h18, 32'h0000_4333);
      write_reg(8'h18, 32'h0);
      read_chk(8'h18, 32'h0000_0002);
      write_reg(8'h14, 32'hffff_ffff);
      read_chk(8'h14, 32'h001f_4333);
      write_reg(8'h2c, 32'hffff_ffff);
      read_chk(8'h2c, 32'h0000_0003);
      write_reg(8'h24, 32'hffff_ffff);
      read_chk(8'h24, 32'h0201_4300);
   endtask

   task automatic t_sequence;
      int n;
      write_reg(8'h14, 32'h0002_4233);
      write_reg(8'h18, 32'h0000_4121);
      write_reg(8'h1c, 32'h0002_0310);
      pg = 4'b1011;
      wake = 1'b1;
      wait_state(3'd2, 10, n);
      check("waking one", 32'h0000_0020, seen);
      wait_state(3'd3, 66000, n);
      check("waking two", 32'h0000_4233, seen);
      read_chk(8'h24, 32'h2003_4233);
      // Phase-locked supply not good yet, so the state must hold
      repeat (8) read_chk(8'h24, 32'h2003_4233);
      write_reg(8'h2c, 32'h0000_0001);
      @(posedge clk_sys_i);
      #1;
      check("master off", 32'h0000_4231, seen);
      write_reg(8'h2c, 32'h0000_0003);
      pg = 4'b1111;
      wait_state(3'd5, 10, n);
      check("awake", 32'h0000_4123, seen);
      sleep = 1'b1;
      pg = 4'b0000;
      // Find the entry edge of sleep phase one from the applied outputs
      n = 0;
      while (n < 10 && seen !== 32'h0000_0310) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      check("sleep one", 32'h0000_0310, seen);
      // Cycles spent in sleep phase one; dwell field 2 means 4 cycles
      n = 0;
      while (n < 10 && seen === 32'h0000_0310) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      check("sleep dwell", 32'h0000_0004, n);
      check("sleep two", power_seq_pkg::CFG_POWERED_DOWN, seen);
      wait_state(3'd7, 10, n);
      read_chk(8'h24, 32'h1007_4300);
   endtask

   // ------------------------------------------------------------
   // Verdict and run control
   // ------------------------------------------------------------
   task automatic end_of_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Main sequence; reset released just after an edge
   initial begin
      repeat (6) @(posedge clk_sys_i);
      #1;
      reset_i = 1'b0;
      @(posedge clk_sys_i);
      #1;
      t_reset();
      t_regs();
      t_sequence();
      end_of_test();
   end

   // Watchdog: the long waking dwell dominates the run time
   initial begin
      #(70000 * 20);
      miscompares++;
      end_of_test();
   end
endmodule
